// File: stop_sel_pkg.sv
// package of constants and types for the servo stop selector
package stop_sel_pkg;
  // register byte offsets
  localparam logic [3:0] CFG_OFS       = 4'h0;
  localparam logic [3:0] STATE_OFS     = 4'h4;
  localparam logic [3:0] IRQ_STAT_OFS  = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFS  = 4'hC;
  // configuration field positions
  localparam int C1_SEL_POS   = 0;  // 2 bits
  localparam int C2_SEL_POS   = 4;  // 3 bits
  localparam int DIS_ACT_POS  = 8;  // 2 bits
  localparam int DIS_HOLD_POS = 12; // 1 bit
  localparam int MAN_REQ_POS  = 16; // 1 bit
  localparam int MAN_KIND_POS = 17; // 1 bit
  // state register field positions
  localparam int ST_POS    = 0;
  localparam int CAUSE_POS = 4;
  localparam int ACT_POS   = 8;
  localparam int HOLD_POS  = 12;
  localparam int IN_POS    = 16;
  // interrupt bit positions
  localparam int IRQ_F1   = 0;
  localparam int IRQ_F2   = 1;
  localparam int IRQ_DIS  = 2;
  localparam int IRQ_DONE = 3;
  // reset values
  localparam logic [31:0] CFG_RST      = 32'h0000_0000;
  localparam logic [3:0]  IRQ_MASK_RST = 4'h0;
  // panel flash half period
  localparam int CLK_HZ        = 20_000_000;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_CYC     = FLASH_HALF_MS * (CLK_HZ / 1000);
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // sequence states, gray along run-stop-hold
  typedef enum logic [1:0] {
    S_RUN  = 2'h0,
    S_STOP = 2'h1,
    S_HOLD = 2'h3
  } seq_state_t;
  // stop causes, higher value is more severe
  typedef enum logic [2:0] {
    CA_NONE = 3'h0,
    CA_MAN  = 3'h1,
    CA_DIS  = 3'h2,
    CA_F2   = 3'h3,
    CA_F1   = 3'h4
  } cause_t;
  // stop actions
  typedef enum logic [2:0] {
    A_COAST = 3'h0,
    A_DB    = 3'h1,
    A_ZERO  = 3'h2,
    A_RAMP  = 3'h3,
    A_ETRQ  = 3'h4
  } action_t;
  // end states after the stop
  typedef enum logic [1:0] {
    H_FREE  = 2'h0,
    H_SHORT = 2'h1,
    H_LOCK  = 2'h2
  } hold_t;
endpackage : stop_sel_pkg

// File: servo_stop_selector.sv
// servo stop selector: stop action and end state choice with axi4-lite registers
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module servo_stop_selector
  import stop_sel_pkg::*;
#(
  parameter logic [23:0] FLASH_CYCLES = 24'(FLASH_CYC)
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // axi4-lite write address and data
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [3:0]  awaddr_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  // axi4-lite write response
  output logic             bvalid_o,
  input  wire logic        bready_i,
  output logic [1:0]       bresp_o,
  // axi4-lite read
  input  wire logic        arvalid_i,
  output logic             arready_o,
  input  wire logic [3:0]  araddr_i,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  // drive pins, asynchronous to sys_clk_i
  input  wire logic        fault1_i,
  input  wire logic        fault2_i,
  input  wire logic        enable_i,
  input  wire logic        motor_stopped_i,
  // power stage commands
  output logic             drive_en_o,
  output logic             shorted_phase_brake_o,
  output logic             speed_zero_o,
  output logic             brake_torque_o,
  output logic             ramp_stop_o,
  output logic             shaft_lock_o,
  // front panel and interrupt
  output logic             ready_panel_code_o,
  output logic             fault_code_o,
  output logic             panel_flash_o,
  output logic             irq_o
);

  // all state of the block
  typedef struct packed {
    logic [3:0]  sync1;    // first sync stage, read only by sync2
    logic [3:0]  sync2;    // synchronised pins
    logic [3:0]  prev;     // last synchronised value, for edges
    seq_state_t  st;       // stop sequence state
    cause_t      cause;    // cause being served
    action_t     act;      // chosen stop action
    hold_t       hold;     // chosen end state
    logic [31:0] cfg;      // configuration word
    logic [3:0]  irq_stat; // sticky events
    logic [3:0]  irq_mask; // event enables
    logic [23:0] fcnt;     // flash timer
    logic        flash;    // flash phase
    logic        aw_got;   // write address taken
    logic [3:0]  aw_adr;   // held write address
    logic        w_got;    // write data taken
    logic [31:0] w_dat;    // held write data
    logic [3:0]  w_stb;    // held strobes
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        drv;      // windings driven
    logic        sht;      // phases shorted
    logic        zsp;      // speed target forced zero
    logic        btq;      // reverse braking torque
    logic        rmp;      // ramp stop active
    logic        lck;      // shaft locked
    logic        rdy;      // ready code shown
    logic        flt;      // fault code shown
    logic        fls;      // panel flash output
    logic        irq;      // interrupt output
  } state_t;

  state_t st_reg;   // registered state
  state_t st_next;  // next state

  // byte-lane write merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] stb);
    logic [31:0] m;
    m = {{8{stb[3]}}, {8{stb[2]}}, {8{stb[1]}}, {8{stb[0]}}};
    return (old & ~m) | (dat & m);
  endfunction : merge

  // next state of the whole block
  always_comb begin
    logic        f1, f2, en, stopped;
    cause_t      want;
    action_t     a;
    hold_t       h;
    logic [3:0]  ev;
    logic [31:0] wr;
    logic        wr_ok;
    logic        do_wr;
    // locals first, so no local keeps a value from an earlier evaluation
    f1      = st_reg.sync2[0];
    f2      = st_reg.sync2[1];
    en      = st_reg.sync2[2];
    stopped = st_reg.sync2[3];
    want    = CA_NONE;
    a       = A_COAST;
    h       = H_FREE;
    ev      = '0;
    wr      = '0;
    wr_ok   = 1'b1;
    do_wr   = st_reg.aw_got & st_reg.w_got & ~st_reg.bvalid;
    st_next = st_reg;
    // pin synchronisers
    st_next.sync1 = {motor_stopped_i, enable_i, fault2_i, fault1_i};
    st_next.sync2 = st_reg.sync1;
    st_next.prev  = st_reg.sync2;
    // most severe condition present
    if (f1) begin
      want = CA_F1;
    end else if (f2) begin
      want = CA_F2;
    end else if (!en) begin
      want = CA_DIS;
    end else if (st_reg.cfg[MAN_REQ_POS]) begin
      want = CA_MAN;
    end else begin
      want = CA_NONE;
    end
    // stop action and end state for that condition
    case (want)
      CA_F1: begin
        case (st_reg.cfg[C1_SEL_POS +: 2])
          2'h1:    begin a = A_DB; h = H_FREE;  end
          2'h2:    begin a = A_DB; h = H_SHORT; end
          default: begin a = A_COAST; h = H_FREE; end // invalid acts as coast
        endcase
      end
      CA_F2: begin
        case (st_reg.cfg[C2_SEL_POS +: 3])
          3'h1:    begin a = A_ZERO; h = H_FREE;  end
          3'h2:    begin a = A_ZERO; h = H_SHORT; end
          3'h3:    begin a = A_DB;   h = H_FREE;  end
          3'h4:    begin a = A_DB;   h = H_SHORT; end
          default: begin a = A_COAST; h = H_FREE; end
        endcase
      end
      CA_DIS: begin
        case (st_reg.cfg[DIS_ACT_POS +: 2])
          2'h1:    a = A_DB;
          2'h2:    a = A_ZERO;
          default: a = A_COAST;
        endcase
        h = st_reg.cfg[DIS_HOLD_POS] ? H_SHORT : H_FREE;
      end
      CA_MAN: begin
        a = st_reg.cfg[MAN_KIND_POS] ? A_ETRQ : A_RAMP;
        h = H_LOCK;
      end
      default: begin
        a = A_COAST;
        h = H_FREE;
      end
    endcase
    // stop sequence
    case (st_reg.st)
      S_RUN: begin
        if (want != CA_NONE) begin
          st_next.st    = S_STOP;
          st_next.cause = want;
          st_next.act   = a;
          st_next.hold  = h;
        end
      end
      S_STOP, S_HOLD: begin
        if (want == CA_NONE) begin
          st_next.st    = S_RUN; // condition gone, drive resumes
          st_next.cause = CA_NONE;
        end else if (want > st_reg.cause) begin
          st_next.st    = S_STOP; // a worse condition restarts the stop
          st_next.cause = want;
          st_next.act   = a;
          st_next.hold  = h;
        end else if (st_reg.st == S_STOP && stopped) begin
          st_next.st   = S_HOLD;
          ev[IRQ_DONE] = 1'b1;
        end
      end
      default: begin
        st_next.st    = S_RUN;
        st_next.cause = CA_NONE;
      end
    endcase
    // power stage commands from the next state
    st_next.drv = 1'b0;
    st_next.sht = 1'b0;
    st_next.zsp = 1'b0;
    st_next.btq = 1'b0;
    st_next.rmp = 1'b0;
    st_next.lck = 1'b0;
    case (st_next.st)
      S_STOP: begin
        case (st_next.act)
          A_DB:    st_next.sht = 1'b1;
          A_ZERO:  begin
            st_next.drv = 1'b1;
            st_next.zsp = 1'b1;
            st_next.btq = 1'b1;
          end
          A_RAMP:  begin
            st_next.drv = 1'b1;
            st_next.rmp = 1'b1;
          end
          A_ETRQ:  begin
            st_next.drv = 1'b1;
            st_next.btq = 1'b1;
          end
          default: st_next.drv = 1'b0;
        endcase
      end
      S_HOLD: begin
        case (st_next.hold)
          H_SHORT: st_next.sht = 1'b1;
          H_LOCK:  begin
            st_next.drv = 1'b1;
            st_next.lck = 1'b1;
          end
          default: st_next.drv = 1'b0;
        endcase
      end
      default: st_next.drv = 1'b1;
    endcase
    // panel: ready without fault, flashing code with one
    if (f1 || f2) begin
      if (st_reg.fcnt >= FLASH_CYCLES - 24'h1) begin
        st_next.fcnt  = '0;
        st_next.flash = ~st_reg.flash;
      end else begin
        st_next.fcnt = st_reg.fcnt + 24'h1;
      end
    end else begin
      st_next.fcnt  = '0;
      st_next.flash = 1'b1; // flash restarts lit on each fault
    end
    st_next.rdy = ~(f1 | f2);
    st_next.flt = f1 | f2;
    st_next.fls = (f1 | f2) & st_next.flash;
    // pin events
    ev[IRQ_F1]  = f1 & ~st_reg.prev[0];
    ev[IRQ_F2]  = f2 & ~st_reg.prev[1];
    ev[IRQ_DIS] = ~en & st_reg.prev[2];
    // axi write channels, taken in either order
    st_next.awready = awvalid_i & ~st_reg.awready & ~st_reg.aw_got & ~st_reg.bvalid;
    st_next.wready  = wvalid_i & ~st_reg.wready & ~st_reg.w_got & ~st_reg.bvalid;
    if (awvalid_i && st_reg.awready) begin
      st_next.aw_got = 1'b1;
      st_next.aw_adr = awaddr_i;
    end
    if (wvalid_i && st_reg.wready) begin
      st_next.w_got = 1'b1;
      st_next.w_dat = wdata_i;
      st_next.w_stb = wstrb_i;
    end
    if (do_wr) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      case (st_reg.aw_adr)
        CFG_OFS:      st_next.cfg = merge(st_reg.cfg, st_reg.w_dat, st_reg.w_stb);
        STATE_OFS:    wr_ok = 1'b1; // read only, write ignored
        IRQ_STAT_OFS: wr = merge(32'h0, st_reg.w_dat, st_reg.w_stb);
        IRQ_MASK_OFS: st_next.irq_mask = 4'(merge({28'h0, st_reg.irq_mask}, st_reg.w_dat, st_reg.w_stb));
        default:      wr_ok = 1'b0;
      endcase
      st_next.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (st_reg.bvalid && bready_i) begin
      st_next.bvalid = 1'b0;
    end
    // sticky events: write one clears, a new event wins
    st_next.irq_stat = (st_reg.irq_stat & ~wr[3:0]) | ev;
    st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);
    // axi read channel
    st_next.arready = arvalid_i & ~st_reg.arready & ~st_reg.rvalid;
    if (arvalid_i && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = RESP_OKAY;
      case (araddr_i)
        CFG_OFS:      st_next.rdata = st_reg.cfg;
        STATE_OFS:    begin
          st_next.rdata = '0;
          st_next.rdata[ST_POS +: 2]    = st_reg.st;
          st_next.rdata[CAUSE_POS +: 3] = st_reg.cause;
          st_next.rdata[ACT_POS +: 3]   = st_reg.act;
          st_next.rdata[HOLD_POS +: 2]  = st_reg.hold;
          st_next.rdata[IN_POS +: 4]    = st_reg.sync2;
        end
        IRQ_STAT_OFS: st_next.rdata = {28'h0, st_reg.irq_stat};
        IRQ_MASK_OFS: st_next.rdata = {28'h0, st_reg.irq_mask};
        default:      begin
          st_next.rdata = '0;
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st_reg.rvalid && rready_i) begin
      st_next.rvalid = 1'b0;
    end
  end

  // state register, synchronous reset
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      st_reg          <= '0;
      st_reg.st       <= S_RUN;
      st_reg.cause    <= CA_NONE;
      st_reg.act      <= A_COAST;
      st_reg.hold     <= H_FREE;
      st_reg.cfg      <= CFG_RST;
      st_reg.irq_mask <= IRQ_MASK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign awready_o             = st_reg.awready;
  assign wready_o              = st_reg.wready;
  assign bvalid_o              = st_reg.bvalid;
  assign bresp_o               = st_reg.bresp;
  assign arready_o             = st_reg.arready;
  assign rvalid_o              = st_reg.rvalid;
  assign rdata_o               = st_reg.rdata;
  assign rresp_o               = st_reg.rresp;
  assign drive_en_o            = st_reg.drv;
  assign shorted_phase_brake_o = st_reg.sht;
  assign speed_zero_o          = st_reg.zsp;
  assign brake_torque_o        = st_reg.btq;
  assign ramp_stop_o           = st_reg.rmp;
  assign shaft_lock_o          = st_reg.lck;
  assign ready_panel_code_o    = st_reg.rdy;
  assign fault_code_o          = st_reg.flt;
  assign panel_flash_o         = st_reg.fls;
  assign irq_o                 = st_reg.irq;

endmodule : servo_stop_selector

// File: servo_stop_selector_props.sv
// checker of the stop selector power stage and panel outputs
`timescale 1ns/10ps
module servo_stop_selector_props (
  // clock, reset and fault pin
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic fault1_i,
  // power stage commands
  input wire logic drive_en_o,
  input wire logic shorted_phase_brake_o,
  input wire logic speed_zero_o,
  input wire logic brake_torque_o,
  input wire logic ramp_stop_o,
  input wire logic shaft_lock_o,
  // panel
  input wire logic ready_panel_code_o,
  input wire logic fault_code_o,
  input wire logic panel_flash_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_short;
    shorted_phase_brake_o |-> !drive_en_o && !brake_torque_o;
  endproperty
  a_short: assert property (p_short) else $error("phases shorted while driven");
  property p_zero;
    speed_zero_o |-> drive_en_o && brake_torque_o;
  endproperty
  a_zero: assert property (p_zero) else $error("zero speed stop without braking");
  property p_ramp;
    ramp_stop_o |-> drive_en_o && !brake_torque_o && !speed_zero_o;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp stop mixed with braking");
  property p_etrq;
    brake_torque_o |-> drive_en_o && !ramp_stop_o && !shaft_lock_o;
  endproperty
  a_etrq: assert property (p_etrq) else $error("braking torque without drive");
  property p_lock;
    shaft_lock_o |-> drive_en_o && !shorted_phase_brake_o && !brake_torque_o;
  endproperty
  a_lock: assert property (p_lock) else $error("shaft lock without energised windings");
  property p_fshow;
    $rose(fault1_i) ##1 fault1_i [*2] |=> fault_code_o && !ready_panel_code_o;
  endproperty
  a_fshow: assert property (p_fshow) else $error("fault code late");
  property p_flash;
    panel_flash_o |-> fault_code_o && !ready_panel_code_o;
  endproperty
  a_flash: assert property (p_flash) else $error("flash without fault");
  property p_class1;
    fault1_i [*5] |-> !drive_en_o && !shaft_lock_o;
  endproperty
  a_class1: assert property (p_class1) else $error("windings driven under class I fault");
  c_lock: cover property (shaft_lock_o);
  c_zero: cover property (speed_zero_o);
  c_short: cover property (shorted_phase_brake_o);
endmodule : servo_stop_selector_props

bind servo_stop_selector servo_stop_selector_props u_props (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .fault1_i(fault1_i), .drive_en_o(drive_en_o),
  .shorted_phase_brake_o(shorted_phase_brake_o), .speed_zero_o(speed_zero_o),
  .brake_torque_o(brake_torque_o), .ramp_stop_o(ramp_stop_o), .shaft_lock_o(shaft_lock_o),
  .ready_panel_code_o(ready_panel_code_o), .fault_code_o(fault_code_o), .panel_flash_o(panel_flash_o));

// File: motor_model.sv
// behavioural motor behind the power stage
`timescale 1ns/10ps
module motor_model (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  // power stage commands {drive, short, zero, brake, ramp, lock}
  input  wire logic [5:0] cmd_i,
  input  wire logic       slow_i,
  // speed feedback
  output logic            motor_stopped_o
);
  logic [3:0] speed_reg = 4'h0; // shaft speed, 15 is full speed
  logic [3:0] div_reg   = 4'h0; // slows the decay
  logic [3:0] mask;             // decay rate select
  // friction alone is slow, shorted phases or torque brake fast
  assign mask = (cmd_i[5:4] == 2'h0) ? (slow_i ? 4'h3 : 4'h1) : (slow_i ? 4'h1 : 4'h0);
  // only plain drive accelerates; a lock holds speed at rest
  always @(posedge sys_clk_i) begin
    div_reg <= rstn_i ? div_reg + 4'h1 : 4'h0;
    if (!rstn_i) begin
      speed_reg <= 4'h0;
    end else if (cmd_i == 6'h20) begin
      if (speed_reg != 4'hF) speed_reg <= speed_reg + 4'h1;
    end else if (speed_reg != 4'h0 && (div_reg & mask) == 4'h0) begin
      speed_reg <= speed_reg - 4'h1;
    end
  end
  assign motor_stopped_o = (speed_reg == 4'h0);
endmodule : motor_model

// File: servo_stop_selector_tb.sv
// self-checking bench of the servo stop selector
`timescale 1ns/10ps
module servo_stop_selector_tb;
  import stop_sel_pkg::*;
  logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready, f1, f2, en, slow;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rd, x, cfg;
  logic [1:0]  rsp;
  logic [2:0]  a;
  logic [1:0]  h;
  int          failures, n_compared, cyc, c, s1, s2, da, dh, k;
  wire         awready, wready, bvalid, arready, rvalid, stopped, irq;
  wire         drv, shrt, zro, brk, rmp, lck, rdy, fcode, flash;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [5:0]   outs = {drv, shrt, zro, brk, rmp, lck};
  // small flash count keeps the run short
  servo_stop_selector #(.FLASH_CYCLES(24'h000008)) u_servo_stop_selector (
    .sys_clk_i(clk), .rstn_i(rstn), .awvalid_i(awvalid), .awready_o(awready), .awaddr_i(awaddr),
    .wvalid_i(wvalid), .wready_o(wready), .wdata_i(wdata), .wstrb_i(4'hF), .bvalid_o(bvalid),
    .bready_i(bready), .bresp_o(bresp), .arvalid_i(arvalid), .arready_o(arready), .araddr_i(araddr),
    .rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata), .rresp_o(rresp), .fault1_i(f1),
    .fault2_i(f2), .enable_i(en), .motor_stopped_i(stopped), .drive_en_o(drv),
    .shorted_phase_brake_o(shrt), .speed_zero_o(zro), .brake_torque_o(brk), .ramp_stop_o(rmp),
    .shaft_lock_o(lck), .ready_panel_code_o(rdy), .fault_code_o(fcode), .panel_flash_o(flash),
    .irq_o(irq));
  motor_model u_motor_model (.sys_clk_i(clk), .rstn_i(rstn), .cmd_i(outs), .slow_i(slow),
    .motor_stopped_o(stopped));
  // clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures = failures + 1;
      end_sim();
    end
  end
  function logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : rnd
  // output pattern {drive, short, zero, brake, ramp, lock} of a stop action
  function logic [5:0] avec(input logic [2:0] v);
    case (v)
      A_DB:    return 6'h10;
      A_ZERO:  return 6'h2C;
      A_RAMP:  return 6'h22;
      A_ETRQ:  return 6'h24;
      default: return 6'h00;
    endcase
  endfunction : avec
  function logic [5:0] hvec(input logic [1:0] v);
    return (v == H_SHORT) ? 6'h10 : (v == H_LOCK) ? 6'h21 : 6'h00;
  endfunction : hvec
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task end_sim();
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // write: address and data offered together, each released once taken
  task wr(input logic [3:0] ad, input logic [31:0] d);
    logic ga, gw, ca, cw;
    @(posedge clk);
    awaddr <= ad; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    ga = 1'b0; gw = 1'b0;
    while (!(ga && gw)) begin
      @(negedge clk); ca = awready; cw = wready;
      @(posedge clk);
      if (ca) begin awvalid <= 1'b0; ga = 1'b1; end
      if (cw) begin wvalid <= 1'b0; gw = 1'b1; end
    end
    do @(negedge clk); while (!bvalid);
    rsp = bresp;
    @(posedge clk); bready <= 1'b0;
  endtask : wr
  task rdr(input logic [3:0] ad);
    logic ca;
    @(posedge clk);
    araddr <= ad; arvalid <= 1'b1; rready <= 1'b1;
    do begin @(negedge clk); ca = arready; @(posedge clk); end while (!ca);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    rd = rdata; rsp = rresp;
    @(posedge clk); rready <= 1'b0;
  endtask : rdr
  initial begin
    rstn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0; awaddr = 0; araddr = 0;
    wdata = 0; f1 = 0; f2 = 0; en = 1; slow = 0; x = 32'h0000_0044; failures = 0; n_compared = 0; cyc = 0;
    wt(20); rstn <= 1'b1;
    rdr(CFG_OFS); chk("cfg reset", rd, CFG_RST);
    rdr(IRQ_MASK_OFS); chk("mask reset", rd, 32'(IRQ_MASK_RST));
    rdr(4'h6); chk("unmapped resp", 32'(rsp), 32'(RESP_SLVERR));
    chk("unmapped data", rd, 32'h0);
    wr(4'h6, 32'hFFFF_FFFF); chk("unmapped write resp", 32'(rsp), 32'(RESP_SLVERR));
    // interrupt: raise, clear, masked event
    wr(IRQ_MASK_OFS, 32'h1); wt(40); f1 <= 1'b1; wt(6); @(negedge clk);
    chk("irq", 32'(irq), 32'h1); chk("ready code", 32'(rdy), 32'h0);
    chk("flash lit", 32'(flash), 32'h1);
    wt(8); @(negedge clk); chk("flash dark", 32'(flash), 32'h0);
    rdr(IRQ_STAT_OFS); chk("stat f1", 32'(rd[0]), 32'h1);
    wr(IRQ_STAT_OFS, 32'h1); f2 <= 1'b1; wt(6); @(negedge clk); chk("irq masked", 32'(irq), 32'h0);
    rdr(IRQ_STAT_OFS); chk("stat f2", 32'(rd[1:0]), 32'h2);
    for (int i = 0; i < 34; i++) begin
      c = (i < 3) ? 0 : (i < 8) ? 1 : (i < 14) ? 2 : (i < 16) ? 3 : rnd() % 4;
      s1 = (i < 3) ? i : rnd() % 4;
      s2 = (c == 1 && i < 8) ? i - 3 : rnd() % 5;
      da = (c == 2 && i < 14) ? (i - 8) % 3 : rnd() % 3;
      dh = (c == 2 && i < 14) ? (i - 8) / 3 : rnd() % 2;
      k = (i < 16 && c == 3) ? i - 14 : rnd() % 2;
      a = (c == 0) ? ((s1 % 3 == 0) ? A_COAST : A_DB) : (c == 1) ? ((s2 == 0) ? A_COAST : (s2 < 3) ? A_ZERO : A_DB) :
          (c == 2) ? ((da == 0) ? A_COAST : (da == 1) ? A_DB : A_ZERO) : (k ? A_ETRQ : A_RAMP);
      h = (c == 0) ? ((s1 == 2) ? H_SHORT : H_FREE) : (c == 1) ? ((s2 == 2 || s2 == 4) ? H_SHORT : H_FREE) :
          (c == 2) ? (dh ? H_SHORT : H_FREE) : H_LOCK;
      cfg = 32'(s1) | (32'(s2) << 4) | (32'(da) << 8) | (32'(dh) << 12) | (32'(k) << 17);
      @(posedge clk);
      f1 <= 1'b0; f2 <= 1'b0; en <= 1'b1; slow <= rnd() % 2;
      wr(CFG_OFS, cfg); chk("cfg write resp", 32'(rsp), 32'(RESP_OKAY));
      wt(40); @(negedge clk); chk("run", 32'(outs), 32'h20);
      @(posedge clk);
      case (c)
        0: begin f1 <= 1'b1; f2 <= rnd() % 2; en <= rnd() % 2; end
        1: begin f2 <= 1'b1; en <= rnd() % 2; end
        2: en <= 1'b0;
        default: wr(CFG_OFS, cfg | 32'h0001_0000);
      endcase
      wt(5); @(negedge clk);
      chk("stop action", 32'(outs), 32'(avec(a)));
      chk("ready code", 32'(rdy), 32'(c > 1));
      chk("fault code", 32'(fcode), 32'(c < 2));
      rdr(STATE_OFS); chk("cause", 32'(rd[6:4]), 32'(4 - c));
      wt(100); @(negedge clk); chk("end state", 32'(outs), 32'(hvec(h)));
    end
    end_sim();
  end
endmodule : servo_stop_selector_tb
